// [hdl/efp_ctrl.sv]
`timescale 1ns/1ps
// How it works
// - aux port bits written one are weakly pulled high; low address captured in verify.
// - reset pin held low three machine cycles with oscillator running resets device.
// - serial controller reset after three cycles, transmit halted by four cycles.
// - address latch strobe pulses at one sixth of the oscillator rate.
// - one address latch strobe skipped in each external data access cycle.
// - address latch strobe held high during reset.
// - program read strobe twice per cycle on external fetch, two skipped on data access.
// - program read strobe held high during reset.
// - access select low fetches low addresses externally; high runs them internally.
// - alternate bus select high puts low address and data on port 5.
// - alternate bus select high drives high address byte on port 6.
// - alternate bus select picks ports 0 and 2 or ports 5 and 6.
// - alternate bus uses its own program read strobe.
// - internal timing counts divide-by-two stage edges, so duty cycle is irrelevant.
// - idle halts cpu and dma, state kept, peripherals run.
// - idle ends on an enabled interrupt or hardware reset.
// - power-down stops oscillator; only hardware reset ends it.
// - idle holds strobes high, bus low part floats, high part address, spare ports 5 and 6 0ffh, spare ports 0 and 2 address.
// - power-down drives address strobe low and standard or alternate strobe low.
module efp_ctrl
  import efp_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  // pins from outside
  input wire logic I_OSC_IN,
  input wire logic I_RST_PIN_N,
  input wire logic I_EXT_ACCESS_SEL_N,
  input wire logic I_ALT_FETCH_BUS_SEL,
  input wire logic [7:0] I_P4_PIN,
  // cpu side
  input wire logic [15:0] I_PC_ADDR,
  input wire logic I_XDATA_ACCESS,
  input wire logic I_IDLE_REQ,
  input wire logic I_PDOWN_REQ,
  input wire logic I_IRQ_ENABLED,
  input wire logic I_P4_WR,
  input wire logic [7:0] I_P4_WR_DATA,
  input wire logic I_PROG_VERIFY,
  // strobes
  output logic O_ALE,
  output logic O_PROG_READ_STROBE_N,
  output logic O_ALT_PROG_READ_STROBE_N,
  // standard fetch bus
  output logic [7:0] O_P0_OUT,
  output logic O_P0_OE,
  output logic [7:0] O_P2_OUT,
  output logic O_P2_OE,
  // alternate fetch bus
  output logic [7:0] O_P5_OUT,
  output logic O_P5_OE,
  output logic [7:0] O_P6_OUT,
  output logic O_P6_OE,
  // auxiliary port
  output logic [7:0] O_P4_OUT,
  output logic [7:0] O_P4_OE,
  output logic [7:0] O_P4_PULLUP,
  output logic [7:0] O_P4_RD_DATA,
  output logic [7:0] O_VERIFY_ADDR_LO,
  // core control
  output logic O_DEV_RESET,
  output logic O_SER_RESET,
  output logic O_SER_TX_HALT,
  output logic O_CPU_HALT,
  output logic O_DMA_STOP,
  output logic O_OSC_STOP
);
  //----------------------------------------------------------------
  // pin synchronisers
  //----------------------------------------------------------------
  logic [3:0] pins_s;
  logic [7:0] p4_s;
  logic osc_s;
  logic rst_pin_n_s;
  logic ea_n_s;
  logic alt_sel_s;
  logic osc_prev_q;
  logic div2_q;
  logic div2_prev_q;
  logic ph_evt;
  logic [3:0] ph_q;
  logic mc_end;
  logic xdata_q;
  logic [2:0] rst_mc_q;
  logic dev_rst_q;
  efp_mode_t mode_q;
  logic ext_fetch;
  logic [3:0] ph_half;
  logic addr_phase;
  logic ale_d;
  logic prog_read_strobe_n_d;
  logic alt_prog_read_strobe_n_d;
  logic [7:0] aux_q;

  efp_sync #(.W(4), .RST_VAL(4'hd)) u_pin_sync
  (
    .clk(I_CLK_SYS),
    .rst(I_SYS_RST),
    .d({I_OSC_IN, I_RST_PIN_N, I_EXT_ACCESS_SEL_N, I_ALT_FETCH_BUS_SEL}),
    .q(pins_s)
  );

  efp_sync #(.W(8), .RST_VAL(8'hff)) u_p4_sync
  (
    .clk(I_CLK_SYS),
    .rst(I_SYS_RST),
    .d(I_P4_PIN),
    .q(p4_s)
  );

  assign osc_s = pins_s[3];
  assign rst_pin_n_s = pins_s[2];
  assign ea_n_s = pins_s[1];
  assign alt_sel_s = pins_s[0];

  //----------------------------------------------------------------
  // slot decoding
  //----------------------------------------------------------------
  function automatic logic ale_slot(input logic [3:0] p);
    ale_slot = (p <= EFP_ALE_LAST);
  endfunction

  function automatic logic rd_slot(input logic [3:0] p);
    rd_slot = (p >= EFP_RD_FIRST) && (p <= EFP_RD_LAST);
  endfunction

  //----------------------------------------------------------------
  // oscillator divide and machine cycle phase
  //----------------------------------------------------------------
  // divide-by-two flop toggles on each oscillator rising edge
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      osc_prev_q <= 1'b1; // matches synchroniser reset level, no false edge
      div2_q <= 1'b0;
      div2_prev_q <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_s;
      div2_prev_q <= div2_q;
      if (osc_s && !osc_prev_q)
      begin
        div2_q <= ~div2_q;
      end
    end
  end

  // each edge of the divided clock marks one oscillator period
  assign ph_evt = (div2_q != div2_prev_q);
  assign mc_end = ph_evt && (ph_q == EFP_PH_LAST);

  // phase counter 0..11 across one machine cycle
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      ph_q <= 4'h0;
    end
    else if (ph_evt)
    begin
      ph_q <= (ph_q == EFP_PH_LAST) ? 4'h0 : ph_q + 4'h1;
    end
  end

  // data access flag held for a whole machine cycle
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      xdata_q <= 1'b0;
    end
    else if (mc_end)
    begin
      xdata_q <= I_XDATA_ACCESS;
    end
  end

  //----------------------------------------------------------------
  // reset pin qualification
  //----------------------------------------------------------------
  // count whole machine cycles with the pin low, saturating at four
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      rst_mc_q <= 3'h0;
    end
    else if (rst_pin_n_s)
    begin
      rst_mc_q <= 3'h0;
    end
    else if (mc_end && rst_mc_q != EFP_SER_TX_MAX_MC)
    begin
      rst_mc_q <= rst_mc_q + 3'h1;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      dev_rst_q <= 1'b1;
    end
    else if (rst_pin_n_s)
    begin
      dev_rst_q <= 1'b0;
    end
    else if (rst_mc_q >= EFP_RST_HOLD_MC)
    begin
      dev_rst_q <= 1'b1;
    end
  end

  // serial controller sees reset at three, transmit stops by four
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_SER_RESET <= 1'b1;
      O_SER_TX_HALT <= 1'b1;
      O_DEV_RESET <= 1'b1;
    end
    else
    begin
      O_SER_RESET <= dev_rst_q;
      O_SER_TX_HALT <= dev_rst_q && (rst_mc_q == EFP_SER_TX_MAX_MC);
      O_DEV_RESET <= dev_rst_q;
    end
  end

  //----------------------------------------------------------------
  // power modes
  //----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      mode_q <= EFP_MODE_RUN;
    end
    else
    begin
      case (mode_q)
        EFP_MODE_RUN:
        begin
          if (dev_rst_q)
            mode_q <= EFP_MODE_RUN;
          else if (I_PDOWN_REQ)
            mode_q <= EFP_MODE_PDOWN;
          else if (I_IDLE_REQ)
            mode_q <= EFP_MODE_IDLE;
        end
        EFP_MODE_IDLE:
        begin
          if (I_IRQ_ENABLED || dev_rst_q)
            mode_q <= EFP_MODE_RUN;
        end
        EFP_MODE_PDOWN:
        begin
          if (!rst_pin_n_s)
            mode_q <= EFP_MODE_RUN;
        end
        default:
        begin
          mode_q <= EFP_MODE_RUN;
        end
      endcase
    end
  end

  // core halt controls
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_CPU_HALT <= 1'b0;
      O_DMA_STOP <= 1'b0;
      O_OSC_STOP <= 1'b0;
    end
    else
    begin
      O_CPU_HALT <= (mode_q != EFP_MODE_RUN);
      O_DMA_STOP <= (mode_q != EFP_MODE_RUN);
      O_OSC_STOP <= (mode_q == EFP_MODE_PDOWN);
    end
  end

  //----------------------------------------------------------------
  // strobe generation
  //----------------------------------------------------------------
  assign ext_fetch = !ea_n_s || (I_PC_ADDR > EFP_INT_ROM_TOP);
  assign ph_half = (ph_q >= EFP_PH_HALF) ? ph_q - EFP_PH_HALF : ph_q;
  assign addr_phase = (ph_half < EFP_RD_FIRST);

  always_comb
  begin
    ale_d = 1'b1;
    prog_read_strobe_n_d = 1'b1;
    alt_prog_read_strobe_n_d = 1'b1;
    if (dev_rst_q)
    begin
      ale_d = 1'b1;
    end
    else if (mode_q == EFP_MODE_PDOWN)
    begin
      ale_d = 1'b0;
      prog_read_strobe_n_d = alt_sel_s;
      alt_prog_read_strobe_n_d = !alt_sel_s;
    end
    else if (mode_q == EFP_MODE_IDLE)
    begin
      ale_d = 1'b1;
    end
    else
    begin
      ale_d = ale_slot(ph_half) && !(xdata_q && ph_q >= EFP_PH_HALF);
      if (ext_fetch && rd_slot(ph_half) && !xdata_q)
      begin
        prog_read_strobe_n_d = alt_sel_s;
        alt_prog_read_strobe_n_d = !alt_sel_s;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_ALE <= 1'b1;
      O_PROG_READ_STROBE_N <= 1'b1;
      O_ALT_PROG_READ_STROBE_N <= 1'b1;
    end
    else
    begin
      O_ALE <= ale_d;
      O_PROG_READ_STROBE_N <= prog_read_strobe_n_d;
      O_ALT_PROG_READ_STROBE_N <= alt_prog_read_strobe_n_d;
    end
  end

  //----------------------------------------------------------------
  // fetch bus drive
  //----------------------------------------------------------------
  // low byte driven in the address slots, released while strobe reads
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_P0_OUT <= EFP_PORT_IDLE_VAL;
      O_P0_OE <= 1'b0;
      O_P2_OUT <= EFP_PORT_IDLE_VAL;
      O_P2_OE <= 1'b0;
      O_P5_OUT <= EFP_PORT_IDLE_VAL;
      O_P5_OE <= 1'b0;
      O_P6_OUT <= EFP_PORT_IDLE_VAL;
      O_P6_OE <= 1'b0;
    end
    else
    begin
      O_P0_OUT <= I_PC_ADDR[7:0];
      O_P2_OUT <= I_PC_ADDR[15:8];
      O_P5_OUT <= alt_sel_s ? I_PC_ADDR[7:0] : EFP_PORT_IDLE_VAL;
      O_P6_OUT <= alt_sel_s ? I_PC_ADDR[15:8] : EFP_PORT_IDLE_VAL;
      O_P0_OE <= 1'b0;
      O_P2_OE <= 1'b0;
      O_P5_OE <= 1'b0;
      O_P6_OE <= 1'b0;
      if (!dev_rst_q && ext_fetch && mode_q == EFP_MODE_RUN && !xdata_q)
      begin
        O_P0_OE <= !alt_sel_s && addr_phase;
        O_P2_OE <= !alt_sel_s;
        O_P5_OE <= alt_sel_s && addr_phase;
        O_P6_OE <= alt_sel_s;
      end
      else if (!dev_rst_q && ext_fetch && mode_q == EFP_MODE_IDLE)
      begin
        O_P2_OE <= !alt_sel_s;
        O_P6_OE <= alt_sel_s;
      end
    end
  end

  //----------------------------------------------------------------
  // auxiliary port
  //----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      aux_q <= EFP_AUX_PORT_RST;
      O_VERIFY_ADDR_LO <= 8'h00;
    end
    else
    begin
      if (I_P4_WR)
        aux_q <= I_P4_WR_DATA;
      if (I_PROG_VERIFY)
        O_VERIFY_ADDR_LO <= p4_s;
    end
  end

  // ones get a weak pullup and read back the pin, zeros drive low
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      O_P4_OUT <= 8'h00;
      O_P4_OE <= 8'h00;
      O_P4_PULLUP <= EFP_AUX_PORT_RST;
      O_P4_RD_DATA <= 8'hff;
    end
    else
    begin
      O_P4_OUT <= 8'h00;
      O_P4_OE <= ~aux_q;
      O_P4_PULLUP <= aux_q;
      O_P4_RD_DATA <= p4_s;
    end
  end

  //----------------------------------------------------------------
  // checks
  //----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);

  chk_ale_rst_high: assert property (dev_rst_q |=> O_ALE)
    else $error("ale not high in reset");
  chk_prog_read_strobe_n_rst_high: assert property (dev_rst_q |=> O_PROG_READ_STROBE_N)
    else $error("program strobe not high in reset");
  chk_pd_ale_low: assert property
    (mode_q == EFP_MODE_PDOWN && !dev_rst_q |=> !O_ALE)
    else $error("ale not low in power-down");
  chk_pd_alt_strobe: assert property
    (mode_q == EFP_MODE_PDOWN && !dev_rst_q && alt_sel_s
     |=> O_PROG_READ_STROBE_N && !O_ALT_PROG_READ_STROBE_N)
    else $error("power-down strobes wrong on alternate bus");
  chk_idle_strobes: assert property
    (mode_q == EFP_MODE_IDLE |=> O_ALE && O_PROG_READ_STROBE_N
     && O_ALT_PROG_READ_STROBE_N)
    else $error("idle strobes not high");
  chk_rst_three_mc: assert property
    ($rose(dev_rst_q) |-> $past(rst_mc_q) >= EFP_RST_HOLD_MC)
    else $error("reset taken before three machine cycles");
  chk_tx_halt_four: assert property
    ($rose(O_SER_TX_HALT) |-> $past(rst_mc_q) == EFP_SER_TX_MAX_MC)
    else $error("transmit halt at wrong count");
  chk_ale_skip_xdata: assert property
    (xdata_q && ph_q >= EFP_PH_HALF && mode_q == EFP_MODE_RUN && !dev_rst_q
     |=> !O_ALE)
    else $error("ale not skipped in data access");
  chk_prog_read_strobe_n_skip_xdata: assert property
    (xdata_q && mode_q == EFP_MODE_RUN && !dev_rst_q
     |=> O_PROG_READ_STROBE_N && O_ALT_PROG_READ_STROBE_N)
    else $error("program strobe not skipped in data access");
  chk_idle_exit_irq: assert property
    (mode_q == EFP_MODE_IDLE && I_IRQ_ENABLED |=> mode_q == EFP_MODE_RUN)
    else $error("idle not left on interrupt");

  cov_idle_entry: cover property (mode_q == EFP_MODE_RUN ##1 mode_q == EFP_MODE_IDLE);
  cov_pd_entry: cover property (mode_q == EFP_MODE_RUN ##1 mode_q == EFP_MODE_PDOWN);
  cov_xdata_cycle: cover property (mc_end && I_XDATA_ACCESS);
  cov_pin_reset: cover property ($rose(dev_rst_q));
endmodule // efp_ctrl

// [hdl/efp_common.sv]
package efp_pkg;
  // machine cycle framing
  localparam int unsigned EFP_MC_OSC_PERIODS = 12;
  localparam logic [3:0] EFP_PH_LAST = 4'hb;
  localparam logic [3:0] EFP_PH_HALF = 4'h6;
  // reset pin qualification, in machine cycles
  localparam logic [2:0] EFP_RST_HOLD_MC = 3'h3;
  localparam logic [2:0] EFP_SER_TX_MAX_MC = 3'h4;
  // strobe slots inside one half machine cycle (osc periods)
  localparam logic [3:0] EFP_ALE_LAST = 4'h1;
  localparam logic [3:0] EFP_RD_FIRST = 4'h3;
  localparam logic [3:0] EFP_RD_LAST = 4'h5;
  // highest internal program address
  localparam logic [15:0] EFP_INT_ROM_TOP = 16'h0fff;
  // reset values
  localparam logic [7:0] EFP_AUX_PORT_RST = 8'hff;
  localparam logic [7:0] EFP_PORT_IDLE_VAL = 8'hff;
  // power modes
  typedef enum logic [1:0]
  {
    EFP_MODE_RUN = 2'b00,
    EFP_MODE_IDLE = 2'b01,
    EFP_MODE_PDOWN = 2'b10
  } efp_mode_t;
endpackage

`timescale 1ns/1ps
module efp_sync
#(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  // two flop synchroniser, first stage feeds only the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // efp_sync

// [bench/efp_ext_mem.sv]
`timescale 1ns/1ps
module efp_ext_mem
(
  // clock
  input wire logic i_clk,
  // strobes and bus choice
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_alt_rd_n,
  input wire logic i_alt_sel,
  // address lines of both buses
  input wire logic [7:0] i_lo_std,
  input wire logic [7:0] i_hi_std,
  input wire logic [7:0] i_lo_alt,
  input wire logic [7:0] i_hi_alt,
  // last program address fetched
  output logic [15:0] o_last_addr
);
  logic ale_q = 1'b0;
  logic rd_q = 1'b1;
  logic [7:0] lo_q = 8'h00;
  logic rd_n;
  // the strobe of the selected bus reads the memory
  assign rd_n = i_alt_sel ? i_alt_rd_n : i_rd_n;
  // low byte taken as the address strobe falls, high byte while reading
  always @(posedge i_clk)
  begin
    if (ale_q && !i_ale)
      lo_q <= i_alt_sel ? i_lo_alt : i_lo_std;
    if (rd_q && !rd_n)
      o_last_addr <= {(i_alt_sel ? i_hi_alt : i_hi_std), lo_q};
    ale_q <= i_ale;
    rd_q <= rd_n;
  end
endmodule // efp_ext_mem

// [bench/efp_ctrl_bench.sv]
`timescale 1ns/1ps
module efp_ctrl_bench;
  import efp_pkg::*;
  typedef struct {int sel; logic [31:0] exp;} efp_note_t;
  logic I_CLK_SYS, I_SYS_RST, I_OSC_IN, I_RST_PIN_N, I_EXT_ACCESS_SEL_N, I_ALT_FETCH_BUS_SEL;
  logic [7:0] I_P4_PIN, I_P4_WR_DATA, O_P0_OUT, O_P2_OUT, O_P5_OUT, O_P6_OUT;
  logic [7:0] O_P4_OUT, O_P4_OE, O_P4_PULLUP, O_P4_RD_DATA, O_VERIFY_ADDR_LO;
  logic [15:0] I_PC_ADDR, mem_addr, pc;
  logic I_XDATA_ACCESS, I_IDLE_REQ, I_PDOWN_REQ, I_IRQ_ENABLED, I_P4_WR, I_PROG_VERIFY;
  logic O_ALE, O_PROG_READ_STROBE_N, O_ALT_PROG_READ_STROBE_N, O_P0_OE, O_P2_OE, O_P5_OE;
  logic O_P6_OE, O_DEV_RESET, O_SER_RESET, O_SER_TX_HALT, O_CPU_HALT, O_DMA_STOP, O_OSC_STOP;
  logic ale_p, rd_p, alt_p, p5_p, clr;
  logic [7:0] d8;
  int failures, cmp_count, ale_c, rd_c, alt_c, p5_c, osc_c, seed_v;
  efp_note_t notes[$];
  efp_note_t n;

  efp_ctrl uut (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_OSC_IN(I_OSC_IN),
    .I_RST_PIN_N(I_RST_PIN_N), .I_EXT_ACCESS_SEL_N(I_EXT_ACCESS_SEL_N),
    .I_ALT_FETCH_BUS_SEL(I_ALT_FETCH_BUS_SEL), .I_P4_PIN(I_P4_PIN), .I_PC_ADDR(I_PC_ADDR),
    .I_XDATA_ACCESS(I_XDATA_ACCESS), .I_IDLE_REQ(I_IDLE_REQ), .I_PDOWN_REQ(I_PDOWN_REQ),
    .I_IRQ_ENABLED(I_IRQ_ENABLED), .I_P4_WR(I_P4_WR), .I_P4_WR_DATA(I_P4_WR_DATA),
    .I_PROG_VERIFY(I_PROG_VERIFY), .O_ALE(O_ALE), .O_PROG_READ_STROBE_N(O_PROG_READ_STROBE_N),
    .O_ALT_PROG_READ_STROBE_N(O_ALT_PROG_READ_STROBE_N), .O_P0_OUT(O_P0_OUT), .O_P0_OE(O_P0_OE),
    .O_P2_OUT(O_P2_OUT), .O_P2_OE(O_P2_OE), .O_P5_OUT(O_P5_OUT), .O_P5_OE(O_P5_OE),
    .O_P6_OUT(O_P6_OUT), .O_P6_OE(O_P6_OE), .O_P4_OUT(O_P4_OUT), .O_P4_OE(O_P4_OE),
    .O_P4_PULLUP(O_P4_PULLUP), .O_P4_RD_DATA(O_P4_RD_DATA), .O_VERIFY_ADDR_LO(O_VERIFY_ADDR_LO),
    .O_DEV_RESET(O_DEV_RESET), .O_SER_RESET(O_SER_RESET), .O_SER_TX_HALT(O_SER_TX_HALT),
    .O_CPU_HALT(O_CPU_HALT), .O_DMA_STOP(O_DMA_STOP), .O_OSC_STOP(O_OSC_STOP));

  efp_ext_mem mem (.i_clk(I_CLK_SYS), .i_ale(O_ALE), .i_rd_n(O_PROG_READ_STROBE_N),
    .i_alt_rd_n(O_ALT_PROG_READ_STROBE_N), .i_alt_sel(I_ALT_FETCH_BUS_SEL), .i_lo_std(O_P0_OUT),
    .i_hi_std(O_P2_OUT), .i_lo_alt(O_P5_OUT), .i_hi_alt(O_P6_OUT), .o_last_addr(mem_addr));

  // -------------------------------------------------------------------
  // clock, oscillator and watchdog
  // -------------------------------------------------------------------
  initial
  begin
    I_CLK_SYS = 1'b0;
    forever #2 I_CLK_SYS = ~I_CLK_SYS;
  end
  // oscillator of ten clocks with a 30 percent high time
  always @(negedge I_CLK_SYS)
  begin
    osc_c = (osc_c == 9) ? 0 : osc_c + 1;
    I_OSC_IN <= (osc_c < 3);
  end
  // whole run is near 3600 clocks, so 50000 means a hang
  initial
  begin
    #200000;
    failures++;
    tally_and_finish();
  end

  // -------------------------------------------------------------------
  // observation and scoreboard
  // -------------------------------------------------------------------
  function automatic logic [31:0] obs(input int s);
    case (s)
      0: obs = ale_c;
      1: obs = rd_c;
      2: obs = alt_c;
      3: obs = p5_c;
      4: obs = {31'h0, O_ALE};
      5: obs = {31'h0, O_PROG_READ_STROBE_N};
      6: obs = {31'h0, O_ALT_PROG_READ_STROBE_N};
      7: obs = {30'h0, O_DEV_RESET, O_SER_RESET};
      8: obs = {31'h0, O_SER_TX_HALT};
      9: obs = {30'h0, O_CPU_HALT, O_DMA_STOP};
      10: obs = {31'h0, O_OSC_STOP};
      11: obs = {31'h0, O_P0_OE};
      12: obs = {23'h0, O_P2_OE, O_P2_OUT};
      13: obs = {23'h0, O_P6_OE, O_P6_OUT};
      14: obs = {8'h0, O_P4_OUT, O_P4_OE, O_P4_PULLUP};
      15: obs = {24'h0, O_VERIFY_ADDR_LO};
      16: obs = {24'h0, O_P4_RD_DATA};
      default: obs = {16'h0, mem_addr};
    endcase
  endfunction
  // compare every queued note, then count strobe edges of the open window
  always @(posedge I_CLK_SYS)
  begin
    while (notes.size() > 0)
    begin
      n = notes.pop_front();
      cmp_count++;
      if (obs(n.sel) !== n.exp)
      begin
        failures++;
        $display("MISMATCH t=%0t item %0d exp %h got %h", $time, n.sel, n.exp, obs(n.sel));
      end
    end
    // a cleared window also counts this edge, so it spans whole strobe periods
    if (clr)
    begin
      {ale_c, rd_c, alt_c, p5_c} = '0;
      clr = 1'b0;
    end
    ale_c += (O_ALE === 1'b1 && ale_p === 1'b0);
    rd_c += (O_PROG_READ_STROBE_N === 1'b0 && rd_p === 1'b1);
    alt_c += (O_ALT_PROG_READ_STROBE_N === 1'b0 && alt_p === 1'b1);
    p5_c += (O_P5_OE === 1'b1 && p5_p === 1'b0);
    {ale_p, rd_p, alt_p, p5_p} = {O_ALE, O_PROG_READ_STROBE_N, O_ALT_PROG_READ_STROBE_N, O_P5_OE};
  end

  // -------------------------------------------------------------------
  // driver tasks
  // -------------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge I_CLK_SYS);
  endtask
  task automatic want(input int s, input logic [31:0] e);
    notes.push_back('{s, e});
  endtask
  // count strobe edges over k clocks
  task automatic win(input int k);
    clr = 1'b1;
    tick(k);
  endtask
  // two machine cycles of strobes for one fetch setting
  task automatic run_case(input logic en, input logic alt, input logic xd, input int ea,
                          input int es, input int et);
    I_EXT_ACCESS_SEL_N = en;
    I_ALT_FETCH_BUS_SEL = alt;
    I_XDATA_ACCESS = xd;
    tick(130);
    win(240);
    want(0, ea);
    want(1, es);
    want(2, et);
    $display("fetch case en=%0d alt=%0d xd=%0d done", en, alt, xd);
  endtask
  task automatic tally_and_finish();
    tick(2);
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // -------------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------------
  initial
  begin
    {I_SYS_RST, I_RST_PIN_N, I_EXT_ACCESS_SEL_N, I_OSC_IN, clr} = 5'b11100;
    {I_ALT_FETCH_BUS_SEL, I_XDATA_ACCESS, I_IDLE_REQ, I_PDOWN_REQ} = '0;
    {I_IRQ_ENABLED, I_P4_WR, I_PROG_VERIFY, failures, cmp_count, osc_c} = '0;
    {I_P4_PIN, I_P4_WR_DATA, I_PC_ADDR} = '0;
    seed_v = $urandom(80);
    tick(2);
    want(4, 1);
    want(5, 1);
    tick(1);
    I_SYS_RST = 1'b0;
    tick(10);
    $display("reset defaults test done");
    pc = $urandom;
    I_PC_ADDR = pc;
    run_case(1'b0, 1'b0, 1'b0, 4, 4, 0);
    want(12, {1'b1, pc[15:8]});
    want(17, pc);
    run_case(1'b0, 1'b1, 1'b0, 4, 0, 4);
    want(3, 4);
    want(13, {1'b1, pc[15:8]});
    want(11, 0);
    want(17, pc);
    I_PC_ADDR = pc & EFP_INT_ROM_TOP;
    run_case(1'b1, 1'b0, 1'b0, 4, 0, 0);
    I_PC_ADDR = pc | 16'h1000;
    run_case(1'b1, 1'b0, 1'b0, 4, 4, 0);
    run_case(1'b0, 1'b0, 1'b1, 2, 0, 0);
    run_case(1'b0, 1'b0, 1'b0, 4, 4, 0);
    // idle entry and exit on an interrupt
    I_IDLE_REQ = 1'b1;
    tick(1);
    I_IDLE_REQ = 1'b0;
    tick(4);
    want(9, 3);
    want(4, 1);
    want(5, 1);
    want(6, 1);
    want(11, 0);
    want(12, {1'b1, I_PC_ADDR[15:8]});
    want(13, {1'b0, EFP_PORT_IDLE_VAL});
    win(120);
    want(0, 0);
    I_IRQ_ENABLED = 1'b1;
    tick(3);
    want(9, 0);
    I_IRQ_ENABLED = 1'b0;
    $display("idle test done");
    // power-down on both buses, left only by the reset pin
    for (int a = 0; a < 2; a++)
    begin
      I_ALT_FETCH_BUS_SEL = a[0];
      tick(130);
      I_PDOWN_REQ = 1'b1;
      tick(1);
      I_PDOWN_REQ = 1'b0;
      tick(4);
      want(10, 1);
      want(4, 0);
      want(5, a[0]);
      want(6, !a[0]);
      I_IRQ_ENABLED = 1'b1;
      tick(5);
      want(10, 1);
      I_IRQ_ENABLED = 1'b0;
      I_RST_PIN_N = 1'b0;
      tick(6);
      I_RST_PIN_N = 1'b1;
      tick(10);
      want(10, 0);
      $display("power-down test bus %0d done", a);
    end
    run_case(1'b0, 1'b0, 1'b0, 4, 4, 0);
    // reset pin held low long enough, the bench keeps it four and a half machine cycles
    I_RST_PIN_N = 1'b0;
    tick(180);
    want(7, 0);
    want(8, 0);
    tick(240);
    want(7, 3);
    want(4, 1);
    want(5, 1);
    win(120);
    want(0, 0);
    want(1, 0);
    want(8, 1);
    I_RST_PIN_N = 1'b1;
    tick(20);
    want(7, 0);
    $display("reset pin test done");
    // auxiliary port latch and verify capture
    d8 = $urandom;
    I_P4_WR_DATA = d8;
    I_P4_WR = 1'b1;
    tick(1);
    I_P4_WR = 1'b0;
    tick(2);
    want(14, {8'h00, ~d8, d8});
    d8 = $urandom;
    I_P4_PIN = d8;
    I_PROG_VERIFY = 1'b1;
    tick(6);
    want(15, d8);
    want(16, d8);
    $display("aux port test done");
    tally_and_finish();
  end
endmodule // efp_ctrl_bench
